// [shared/board_glue_map.vh]
// Purpose: address map, field layout and reset values of the board glue
// Assumes: included by bare name from the design files
// Notes: definitions only
`ifndef BOARD_GLUE_MAP_VH
`define BOARD_GLUE_MAP_VH
`define MOD_ADDR_LAST 8'h07
`define ADDR_STATUS 8'h08
`define ADDR_CLKCTL 8'h09
`define CLKSEL_REF 2'h0
`define CLKSEL_DSYM 2'h1
`define CLKSEL_SYSDIV 2'h2
`define CLKSEL_OFF 2'h3
`define CLKCTL_RESET 2'h0
`define DINSEL_PATTERN 2'h0
`define DINSEL_GROUND 2'h1
`define DINSEL_EXTERN 2'h2
`define DINSEL_RESET 2'h1
`define ST_FULL 0
`define ST_OVFL 1
`define ST_EMPTY 2
`define ST_LOCK 3
`define ST_IRQ 4
`define JMP_OPEN 2'h0
`define JMP_12 2'h1
`define JMP_23 2'h2
`endif

// [hw/strobe_clock_mux.v]
// Purpose: picks the sample strobe clock source
// Assumes: clock inputs are sampled levels synchronous to clk
// Notes: output enable high while the strobe pin is driven
`timescale 1ns/10ps
`default_nettype none
`include "board_glue_map.vh"
module strobe_clock_mux (
  input wire clk,
  input wire srst,
  input wire [1:0] clock_select,
  input wire [1:0] strobe_clock_override_jumper,
  input wire reference_clock_in,
  input wire double_symbol_clock,
  input wire system_clock_in,
  output reg sample_strobe_clock,
  output reg sample_strobe_clock_oe
);
  reg sys_half;
  reg [1:0] eff_sel;
  always @(posedge clk) begin
    if (srst) begin
      sys_half <= 1'b0;
    end else if (system_clock_in) begin
      // toggles once per sampled high level of the system clock
      sys_half <= ~sys_half;
    end
  end
  always @* begin
    case (strobe_clock_override_jumper)
      `JMP_12: eff_sel = `CLKSEL_REF;
      `JMP_23: eff_sel = `CLKSEL_DSYM;
      default: eff_sel = clock_select;
    endcase
  end
  always @(posedge clk) begin
    if (srst) begin
      sample_strobe_clock <= 1'b0;
      sample_strobe_clock_oe <= 1'b1;
    end else begin
      case (eff_sel)
        `CLKSEL_REF: sample_strobe_clock <= reference_clock_in;
        `CLKSEL_DSYM: sample_strobe_clock <= double_symbol_clock;
        `CLKSEL_SYSDIV: sample_strobe_clock <= sys_half;
        default: sample_strobe_clock <= 1'b0;
      endcase
      sample_strobe_clock_oe <= (eff_sel != `CLKSEL_OFF);
    end
  end
endmodule
`default_nettype wire

// [hw/data_in_select.v]
// Purpose: drives the modulator 16-bit data input bus
// Assumes: pattern data arrives synchronous to clk
// Notes: the external source mode releases the bus entirely
`timescale 1ns/10ps
`default_nettype none
`include "board_glue_map.vh"
module data_in_select #(
  parameter WIDTH = 16
) (
  input wire clk,
  input wire srst,
  input wire [1:0] source_select,
  input wire [WIDTH-1:0] pattern_data,
  output reg [WIDTH-1:0] mod_din,
  output reg [WIDTH-1:0] mod_din_oe
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge clk) begin
        if (srst) begin
          mod_din[i] <= 1'b0;
          mod_din_oe[i] <= 1'b1;
        end else begin
          case (source_select)
            `DINSEL_PATTERN: begin
              mod_din[i] <= pattern_data[i];
              mod_din_oe[i] <= 1'b1;
            end
            `DINSEL_EXTERN: begin
              mod_din[i] <= 1'b0;
              mod_din_oe[i] <= 1'b0;
            end
            default: begin
              mod_din[i] <= 1'b0;
              mod_din_oe[i] <= 1'b1;
            end
          endcase
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// [hw/board_clock_data_select.v]
// Purpose: board glue between host register link and the modulator
// Assumes: host strobes are one-cycle pulses synchronous to clk
// Notes: no bus beyond the documented address/data access
`timescale 1ns/10ps
`default_nettype none
`include "board_glue_map.vh"
// How it works
// - clock-control value picks reference, double symbol, system/2, or off.
// - register 8 is read-only, mirrors modulator status pins.
// - reads up to 0x07 go to modulator, above return board registers.
// - address 0x08 reads status, 0x09 reads clock control.
// - write at 0x09 updates clock control; 0x00-0x07 forwarded.
// - data bus source: pattern memory, ground, or released for generator.
// - playback start selects pattern, stop selects ground.
// - soft reset hits modulator only; board reset hits both.
// - strobe jumper open lets software choose, else forces source.
// - mode jumper selects normal or in-system programming mode.
// - address jumpers set board address; only matching accesses answered.
// - status bits: full, overflow, empty, lock, interrupt.
module board_clock_data_select #(
  parameter DIN_WIDTH = 16
) (
  input wire clk,
  input wire srst,
  input wire host_wr,
  input wire host_rd,
  input wire [1:0] host_board_addr,
  input wire [7:0] host_addr,
  input wire [7:0] host_wdata,
  output reg [7:0] host_rdata,
  output reg host_rdata_valid,
  input wire soft_reset_req,
  input wire board_reset_req,
  input wire start_playback,
  input wire stop_playback,
  input wire release_din,
  input wire [1:0] glue_mode_jumper,
  input wire [1:0] board_addr_jumper_lo,
  input wire [1:0] board_addr_jumper_hi,
  input wire [1:0] strobe_clock_override_jumper,
  output wire isp_mode,
  output reg mod_wr,
  output reg mod_rd,
  output reg [2:0] mod_addr,
  output reg [7:0] mod_wdata,
  input wire [7:0] mod_rdata,
  input wire mod_rdata_valid,
  output reg mod_reset,
  input wire fifo_full_flag,
  input wire fifo_overflow_flag,
  input wire fifo_empty_flag,
  input wire pll_lock_flag,
  input wire mod_irq,
  input wire reference_clock_in,
  input wire double_symbol_clock,
  input wire system_clock_in,
  output wire sample_strobe_clock,
  output wire sample_strobe_clock_oe,
  input wire [DIN_WIDTH-1:0] pattern_data,
  output wire [DIN_WIDTH-1:0] mod_din,
  output wire [DIN_WIDTH-1:0] mod_din_oe
);
  reg [1:0] strobe_clock_source_select;
  reg [1:0] din_source;
  reg [7:0] board_status_mirror;
  reg mod_rd_pending;
  wire glue_rst;
  wire [1:0] my_addr;
  wire hit;
  wire to_mod;

  assign glue_rst = srst | board_reset_req;
  assign isp_mode = (glue_mode_jumper == `JMP_23);
  assign my_addr = {board_addr_jumper_hi == `JMP_23,
                    board_addr_jumper_lo == `JMP_23};
  // programming mode parks the host side so a half-loaded part stays quiet
  assign hit = (host_board_addr == my_addr) & ~isp_mode;
  assign to_mod = (host_addr <= `MOD_ADDR_LAST);

  always @(posedge clk) begin
    if (glue_rst) begin
      board_status_mirror <= 8'h00;
    end else begin
      board_status_mirror <= 8'h00;
      board_status_mirror[`ST_FULL] <= fifo_full_flag;
      board_status_mirror[`ST_OVFL] <= fifo_overflow_flag;
      board_status_mirror[`ST_EMPTY] <= fifo_empty_flag;
      board_status_mirror[`ST_LOCK] <= pll_lock_flag;
      board_status_mirror[`ST_IRQ] <= mod_irq;
    end
  end

  always @(posedge clk) begin
    if (glue_rst) begin
      strobe_clock_source_select <= `CLKCTL_RESET;
      din_source <= `DINSEL_RESET;
    end else begin
      if (hit && host_wr && host_addr == `ADDR_CLKCTL) begin
        strobe_clock_source_select <= host_wdata[1:0];
      end
      if (start_playback) begin
        din_source <= `DINSEL_PATTERN;
      end else if (stop_playback) begin
        din_source <= `DINSEL_GROUND;
      end else if (release_din) begin
        din_source <= `DINSEL_EXTERN;
      end
    end
  end

  always @(posedge clk) begin
    if (glue_rst) begin
      mod_reset <= 1'b1;
    end else begin
      mod_reset <= soft_reset_req;
    end
  end

  always @(posedge clk) begin
    if (glue_rst) begin
      mod_wr <= 1'b0;
      mod_rd <= 1'b0;
      mod_addr <= 3'h0;
      mod_wdata <= 8'h00;
      mod_rd_pending <= 1'b0;
      host_rdata <= 8'h00;
      host_rdata_valid <= 1'b0;
    end else begin
      mod_wr <= 1'b0;
      mod_rd <= 1'b0;
      host_rdata_valid <= 1'b0;
      if (hit && (host_wr || host_rd) && to_mod) begin
        mod_wr <= host_wr;
        mod_rd <= host_rd & ~host_wr;
        mod_addr <= host_addr[2:0];
        mod_wdata <= host_wdata;
        mod_rd_pending <= host_rd & ~host_wr;
      end else if (hit && host_rd && !host_wr) begin
        host_rdata_valid <= 1'b1;
        case (host_addr)
          `ADDR_STATUS: host_rdata <= board_status_mirror;
          `ADDR_CLKCTL: host_rdata <= {6'h00, strobe_clock_source_select};
          default: host_rdata <= 8'h00;
        endcase
      end
      if (mod_rd_pending && mod_rdata_valid) begin
        mod_rd_pending <= 1'b0;
        host_rdata <= mod_rdata;
        host_rdata_valid <= 1'b1;
      end
    end
  end

  strobe_clock_mux u_strobe (
    .clk(clk),
    .srst(glue_rst),
    .clock_select(strobe_clock_source_select),
    .strobe_clock_override_jumper(strobe_clock_override_jumper),
    .reference_clock_in(reference_clock_in),
    .double_symbol_clock(double_symbol_clock),
    .system_clock_in(system_clock_in),
    .sample_strobe_clock(sample_strobe_clock),
    .sample_strobe_clock_oe(sample_strobe_clock_oe)
  );

  data_in_select #(.WIDTH(DIN_WIDTH)) u_din (
    .clk(clk),
    .srst(glue_rst),
    .source_select(din_source),
    .pattern_data(pattern_data),
    .mod_din(mod_din),
    .mod_din_oe(mod_din_oe)
  );
endmodule
`default_nettype wire

// [sim/glue_checker.sv]
// Purpose: port-level checks on the board glue
// Assumes: host strobes are one-cycle pulses
// Notes: bound to the top module
`timescale 1ns/10ps
`default_nettype none
module glue_checker (
  input wire logic clk,
  input wire logic srst,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [1:0] host_board_addr,
  input wire logic [7:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata,
  input wire logic host_rdata_valid,
  input wire logic soft_reset_req,
  input wire logic board_reset_req,
  input wire logic start_playback,
  input wire logic isp_mode,
  input wire logic [1:0] board_addr_jumper_lo,
  input wire logic [1:0] board_addr_jumper_hi,
  input wire logic [1:0] strobe_clock_override_jumper,
  input wire logic mod_wr,
  input wire logic mod_rd,
  input wire logic [2:0] mod_addr,
  input wire logic [7:0] mod_wdata,
  input wire logic mod_reset,
  input wire logic reference_clock_in,
  input wire logic sample_strobe_clock,
  input wire logic sample_strobe_clock_oe,
  input wire logic [15:0] pattern_data,
  input wire logic [15:0] mod_din,
  input wire logic [15:0] mod_din_oe
);
  logic hit;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  assign hit = !isp_mode && host_board_addr ==
    {board_addr_jumper_hi == 2'h2, board_addr_jumper_lo == 2'h2};
  board_read_a: assert property (
    hit && host_rd && !host_wr && host_addr > 8'h07 |=>
    host_rdata_valid && host_rdata[7:5] == 3'h0) else $error("board read");
  mod_write_a: assert property (hit && host_wr && host_addr <= 8'h07 |=>
    mod_wr && mod_addr == $past(host_addr[2:0])
    && mod_wdata == $past(host_wdata)) else $error("mod write");
  mod_read_a: assert property (
    hit && host_rd && !host_wr && host_addr <= 8'h07 |=> mod_rd && !mod_wr)
    else $error("mod read");
  foreign_a: assert property (!hit |=> !mod_wr && !mod_rd)
    else $error("foreign access");
  soft_reset_a: assert property (soft_reset_req |=> mod_reset)
    else $error("soft reset");
  board_reset_a: assert property (board_reset_req |=> mod_reset
    && mod_din == 16'h0 && mod_din_oe == 16'hffff) else $error("board reset");
  strobe_jumper_a: assert property (
    strobe_clock_override_jumper == 2'h1 && !board_reset_req |=>
    sample_strobe_clock_oe && sample_strobe_clock == $past(reference_clock_in))
    else $error("strobe override");
  playback_a: assert property (start_playback && !board_reset_req |=>
    ##1 mod_din == $past(pattern_data) && mod_din_oe == 16'hffff)
    else $error("playback");
endmodule
bind board_clock_data_select glue_checker chk_i (.*);
`default_nettype wire

// [sim/mod_model.sv]
// Purpose: modulator interface registers seen by the glue
// Assumes: one read outstanding
// Notes: answers after one or two cycles at random
`timescale 1ns/10ps
`default_nettype none
module mod_model (
  input wire logic clk,
  input wire logic mod_reset,
  input wire logic mod_wr,
  input wire logic mod_rd,
  input wire logic [2:0] mod_addr,
  input wire logic [7:0] mod_wdata,
  output logic [7:0] mod_rdata,
  output logic mod_rdata_valid
);
  logic [7:0] regs [8];
  logic [7:0] last = 8'h00;
  logic [1:0] cnt = 2'h0;
  logic [2:0] ra;
  initial begin
    mod_rdata = 8'h00;
    mod_rdata_valid = 1'b0;
  end
  always @(posedge clk) begin
    mod_rdata_valid <= 1'b0;
    // released bus must not keep showing stale data
    mod_rdata <= ~last;
    if (mod_reset) begin
      for (int i = 0; i < 8; i++) regs[i] <= 8'h00;
      cnt <= 2'h0;
    end else begin
      if (mod_wr) regs[mod_addr] <= mod_wdata;
      if (mod_rd) begin
        cnt <= 2'(1 + $urandom % 2);
        ra <= mod_addr;
      end else if (cnt == 2'h1) begin
        mod_rdata_valid <= 1'b1;
        mod_rdata <= regs[ra];
        last <= regs[ra];
        cnt <= 2'h0;
      end else if (cnt != 2'h0) cnt <= cnt - 2'h1;
    end
  end
endmodule
`default_nettype wire

// [sim/board_clock_data_select_tb.sv]
// Purpose: self-checking bench for the board glue
// Assumes: board address 0 set by jumpers
// Notes: read answers are matched against a queue
`timescale 1ns/10ps
`default_nettype none
module board_clock_data_select_tb;
  logic clk = 0, srst = 1, host_wr = 0, host_rd = 0;
  logic soft_reset_req = 0, board_reset_req = 0, release_din = 0;
  logic start_playback = 0, stop_playback = 0;
  logic [1:0] host_board_addr = 0, glue_mode_jumper = 1;
  logic [1:0] board_addr_jumper_lo = 1, board_addr_jumper_hi = 1;
  logic [1:0] strobe_clock_override_jumper = 0;
  logic [7:0] host_addr = 0, host_wdata = 0, host_rdata, mod_rdata;
  logic [7:0] mod_wdata, d, stv;
  logic host_rdata_valid, isp_mode, mod_wr, mod_rd, mod_rdata_valid;
  logic mod_reset, fifo_full_flag, fifo_overflow_flag, fifo_empty_flag;
  logic pll_lock_flag, mod_irq, sample_strobe_clock, sample_strobe_clock_oe;
  logic reference_clock_in = 0, double_symbol_clock = 0, system_clock_in = 0;
  logic [2:0] mod_addr, a;
  logic [15:0] pattern_data = 0, mod_din, mod_din_oe;
  logic [7:0] q[$];
  // reference model of the halved system clock: toggles on each high level
  logic half = 0, half_q = 0;
  int err_count = 0, checked = 0;
  assign stv = {3'h0, mod_irq, pll_lock_flag, fifo_empty_flag,
    fifo_overflow_flag, fifo_full_flag};
  board_clock_data_select dut (.*);
  mod_model far (.*);
  always @(posedge clk) begin
    half_q <= half;
    if (srst || board_reset_req) half <= 1'b0;
    else if (system_clock_in) half <= ~half;
  end
  initial forever #12.5 clk = ~clk;
  task chk(input string n, input [15:0] s, e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("Error %s exp %h got %h", n, e, s);
    end
  endtask
  task end_sim;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task acc(input logic w, input [7:0] ad, dat);
    host_wr = w;
    host_rd = !w;
    host_addr = ad;
    host_wdata = dat;
    @(negedge clk);
    host_wr = 0;
    host_rd = 0;
    repeat (5) @(negedge clk);
  endtask
  task rd(input [7:0] ad, e);
    q.push_back(e);
    acc(0, ad, 8'h00);
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    @(negedge clk);
    s = 0;
    repeat (2) @(negedge clk);
  endtask
  always @(negedge clk) begin
    {reference_clock_in, double_symbol_clock, system_clock_in} <= 3'($urandom);
    pattern_data <= 16'($urandom);
    if (host_rdata_valid === 1'b1) chk("rdata", host_rdata, q.pop_front());
  end
  initial begin
    #50000;
    err_count++;
    end_sim;
  end
  initial begin
    d = 8'($urandom(66));
    {fifo_full_flag, fifo_overflow_flag, fifo_empty_flag, pll_lock_flag,
      mod_irq} = 5'($urandom);
    repeat (3) @(negedge clk);
    srst = 0;
    rd(8'h09, 8'h00);
    rd(8'h08, stv);
    acc(1, 8'h08, 8'hff);
    rd(8'h08, stv);
    rd(8'h0c, 8'h00);
    for (int v = 0; v < 4; v++) begin
      d = 8'($urandom);
      d[1:0] = 2'(v);
      acc(1, 8'h09, d);
      rd(8'h09, {6'h0, d[1:0]});
      chk("strobe_oe", sample_strobe_clock_oe, v != 3);
      chk("strobe", sample_strobe_clock, v == 0 ? reference_clock_in :
        v == 1 ? double_symbol_clock : v == 2 ? half_q : 1'b0);
      strobe_clock_override_jumper = 1;
      @(negedge clk);
      chk("override_oe", sample_strobe_clock_oe, 1'b1);
      chk("override_ref", sample_strobe_clock, reference_clock_in);
      strobe_clock_override_jumper = 2;
      @(negedge clk);
      chk("override_dsym", sample_strobe_clock, double_symbol_clock);
      strobe_clock_override_jumper = 0;
    end
    for (int i = 0; i < 4; i++) begin
      a = 3'($urandom);
      d = 8'($urandom);
      acc(1, {5'h0, a}, d);
      rd({5'h0, a}, d);
    end
    host_board_addr = 2;
    acc(1, 8'h09, 8'h02);
    host_board_addr = 0;
    glue_mode_jumper = 2;
    acc(1, 8'h09, 8'h02);
    chk("isp", isp_mode, 1'b1);
    glue_mode_jumper = 1;
    rd(8'h09, 8'h03);
    pulse(soft_reset_req);
    rd({5'h0, a}, 8'h00);
    rd(8'h09, 8'h03);
    pulse(start_playback);
    chk("din_oe", mod_din_oe, 16'hffff);
    chk("din_pat", mod_din, pattern_data);
    pulse(release_din);
    chk("din_oe", mod_din_oe, 16'h0000);
    pulse(stop_playback);
    chk("din", mod_din, 16'h0000);
    chk("din_oe", mod_din_oe, 16'hffff);
    pulse(start_playback);
    pulse(board_reset_req);
    chk("din_oe", mod_din_oe, 16'hffff);
    chk("din", mod_din, 16'h0000);
    rd(8'h09, 8'h00);
    chk("queue", 16'(q.size()), 16'h0000);
    end_sim;
  end
endmodule
`default_nettype wire
